// ### verification/mcu_instruction_timing_flags_tb.sv
`timescale 1ns/1ps
module mcu_instruction_timing_flags_tb;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] prdata;
  logic        clock_stop;
  logic [11:0] tfa;
  logic [31:0] rd;
  logic        err;
  logic [31:0] p;
  int          mismatches;
  int          total_checks;
  mitf_pkg::mitf_op_t r5[5];

  mitf_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .clock_stop(clock_stop), .watchdog_clear_pulse(), .stack_push(), .stack_push_data(),
    .table_fetch_addr(tfa));

  // The clock toggles every half period of 2 ns.
  always #2 pclk = ~pclk;

  // One APB transfer that holds the request until pready is sampled high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) mismatches++;
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Compares a seen value with the expected one and reports a difference.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Reads a register and compares it.
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rc

  // Executes one instruction with extra field bits and checks its cycle count.
  task automatic run(input mitf_pkg::mitf_op_t op, input logic [31:0] f, input logic [1:0] cy);
    apb(1'b1, mitf_pkg::OFS_INSTR, f | {26'h0, op});
    apb(1'b0, mitf_pkg::OFS_STATUS, 32'h0);
    chk({30'h0, rd[3:2]}, {30'h0, cy});
  endtask : run

  // Prints the verdict and stops the run.
  task automatic end_of_test();
    if (mismatches == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test

  // Cuts a hang short well after the tests should have ended.
  initial begin
    #100000;
    mismatches++;
    end_of_test();
  end

  // Main sequence of instruction tests.
  initial begin
    pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; mismatches = 0; total_checks = 0;
    r5 = '{mitf_pkg::jump_op, mitf_pkg::call_op, mitf_pkg::subroutine_exit,
           mitf_pkg::subroutine_exit_load_work, mitf_pkg::interrupt_exit};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rc(mitf_pkg::OFS_FLAGS, 32'h0);
    apb(1'b1, mitf_pkg::OFS_MEM, 32'h81);
    run(mitf_pkg::rotate_right_to_work, 32'h0, 2'h1);
    rc(mitf_pkg::OFS_WORK, 32'hc0);
    run(mitf_pkg::rotate_left_in_place, 32'h0, 2'h1);
    rc(mitf_pkg::OFS_MEM, 32'h03);
    rc(mitf_pkg::OFS_FLAGS, 32'h0);
    apb(1'b1, mitf_pkg::OFS_FLAGS, 32'h1);
    apb(1'b1, mitf_pkg::OFS_MEM, 32'h40);
    run(mitf_pkg::rotate_left_carry_in_place, 32'h0, 2'h1);
    rc(mitf_pkg::OFS_MEM, 32'h81);
    rc(mitf_pkg::OFS_FLAGS, 32'h0);
    run(mitf_pkg::rotate_right_carry_to_work, 32'h0, 2'h1);
    rc(mitf_pkg::OFS_WORK, 32'h40);
    rc(mitf_pkg::OFS_FLAGS, 32'h1);
    run(mitf_pkg::copy_imm_to_work, 32'h005a_0000, 2'h1);
    run(mitf_pkg::copy_work_to_mem, 32'h0, 2'h1);
    rc(mitf_pkg::OFS_MEM, 32'h5a);
    run(mitf_pkg::bit_set_op, 32'h0, 2'h1);
    run(mitf_pkg::bit_clear_op, 32'h0c0, 2'h1);
    rc(mitf_pkg::OFS_MEM, 32'h53);
    run(mitf_pkg::copy_mem_to_work, 32'h0, 2'h1);
    rc(mitf_pkg::OFS_WORK, 32'h53);
    run(mitf_pkg::nibble_exchange_in_place, 32'h0, 2'h1);
    rc(mitf_pkg::OFS_MEM, 32'h35);
    run(mitf_pkg::clear_op, 32'h0, 2'h1);
    rc(mitf_pkg::OFS_MEM, 32'h0);
    run(mitf_pkg::set_byte_op, 32'h0, 2'h1);
    run(mitf_pkg::idle_op, 32'h0, 2'h1);
    rc(mitf_pkg::OFS_MEM, 32'hff);
    rc(mitf_pkg::OFS_FLAGS, 32'h1);
    foreach (r5[i]) run(r5[i], 32'h0123_0000, 2'h2);
    run(mitf_pkg::jump_op, 32'h0123_0000, 2'h2);
    rc(mitf_pkg::OFS_PC, 32'h123);
    run(mitf_pkg::skip_after_increment, 32'h0, 2'h2);
    rc(mitf_pkg::OFS_PC, 32'h125);
    rc(mitf_pkg::OFS_MEM, 32'h0);
    run(mitf_pkg::skip_when_zero_load_work, 32'h0, 2'h2);
    rc(mitf_pkg::OFS_WORK, 32'h0);
    apb(1'b1, mitf_pkg::OFS_MEM, 32'h04);
    run(mitf_pkg::skip_when_zero, 32'h0, 2'h1);
    run(mitf_pkg::skip_when_bit_one, 32'h080, 2'h2);
    run(mitf_pkg::skip_when_bit_zero, 32'h080, 2'h1);
    run(mitf_pkg::skip_after_decrement_to_work, 32'h0, 2'h1);
    rc(mitf_pkg::OFS_WORK, 32'h03);
    run(mitf_pkg::rotate_right_in_place, 32'h200, 2'h2);
    run(mitf_pkg::clear_op, 32'h200, 2'h2);
    rc(mitf_pkg::OFS_MEM, 32'h04);
    rc(mitf_pkg::OFS_PC, 32'h100);
    rc(mitf_pkg::OFS_FLAGS, 32'h1);
    apb(1'b1, mitf_pkg::OFS_FLAGS, 32'h6);
    run(mitf_pkg::watchdog_preclear_first, 32'h0, 2'h1);
    run(mitf_pkg::watchdog_preclear_first, 32'h0, 2'h1);
    rc(mitf_pkg::OFS_FLAGS, 32'h6);
    run(mitf_pkg::watchdog_preclear_second, 32'h0, 2'h1);
    rc(mitf_pkg::OFS_FLAGS, 32'h0);
    apb(1'b1, mitf_pkg::OFS_FLAGS, 32'h6);
    run(mitf_pkg::watchdog_preclear_second, 32'h0, 2'h1);
    run(mitf_pkg::idle_op, 32'h0, 2'h1);
    run(mitf_pkg::watchdog_preclear_first, 32'h0, 2'h1);
    rc(mitf_pkg::OFS_FLAGS, 32'h6);
    run(mitf_pkg::watchdog_clear, 32'h0, 2'h1);
    rc(mitf_pkg::OFS_FLAGS, 32'h0);
    apb(1'b1, mitf_pkg::OFS_WORK, 32'h12);
    apb(1'b1, mitf_pkg::OFS_PROG_WORD, 32'h7f55);
    run(mitf_pkg::table_read_last_page, 32'h0, 2'h2);
    rc(mitf_pkg::OFS_TABLE_ADDR, 32'hf12);
    chk({20'h0, tfa}, 32'hf12);
    rc(mitf_pkg::OFS_MEM, 32'h55);
    chk({25'h0, rd[22:16]}, 32'h0);
    apb(1'b0, mitf_pkg::OFS_STATUS, 32'h0);
    chk({25'h0, rd[22:16]}, 32'h7f);
    apb(1'b1, mitf_pkg::OFS_PROG_WORD, 32'h0166);
    apb(1'b0, mitf_pkg::OFS_PC, 32'h0);
    p = rd;
    run(mitf_pkg::table_read_current_page, 32'h0, 2'h2);
    rc(mitf_pkg::OFS_TABLE_ADDR, {20'h0, p[11:8], 8'h12});
    chk({20'h0, tfa}, {20'h0, p[11:8], 8'h12});
    rc(mitf_pkg::OFS_MEM, 32'h66);
    apb(1'b1, mitf_pkg::OFS_FLAGS, 32'h2);
    run(mitf_pkg::power_down_op, 32'h0, 2'h1);
    rc(mitf_pkg::OFS_FLAGS, 32'h4);
    chk({31'h0, clock_stop}, 32'h1);
    apb(1'b1, mitf_pkg::OFS_INSTR, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, mitf_pkg::OFS_WAKE, 32'h1);
    @(posedge pclk);
    chk({31'h0, clock_stop}, 32'h0);
    apb(1'b0, 8'h3c, 32'h0);
    chk({31'h0, err}, 32'h1);
    end_of_test();
  end
endmodule : mcu_instruction_timing_flags_tb

// ### verilog/mitf_core.sv
`timescale 1ns/1ps
// What this block does
// - Plain rotates shift one bit, one cycle, no flags.
// - Carry rotates pass the bit through carry.
// - Copies move data in one cycle, no flags.
// - Bit clear or set touches one bit.
// - Jump, call and returns take two cycles.
// - Skips take two cycles only when skipping.
// - Writing program counter low byte costs two cycles.
// - Pre-clear pair clears flags only back to back.
// - Power-down runs one cycle, updates both flags.
// - Current-page table read fills latch and memory.
// - Last-page table read uses the last page.
// - Nibble exchange swaps halves in one cycle.
// - Increment or decrement skips on zero result.
// - Byte-zero skip, variant also loads work register.
// - Bit-test skips on bit zero or one.
// - Watchdog clear clears counter and both flags.
// - Power-down stops clock, sets flag, clears timeout.
// - Call pushes next address, loads the target.
module mitf_core #(
  parameter int unsigned APB_AW = 8
) (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [APB_AW-1:0]         paddr,
  input  wire logic [31:0]               pwdata,
  output logic                           pready,
  output logic                           pslverr,
  output logic [31:0]                    prdata,
  output logic                           clock_stop,
  output logic                           watchdog_clear_pulse,
  output logic                           stack_push,
  output logic [mitf_pkg::PC_W-1:0]      stack_push_data,
  output logic [mitf_pkg::PC_W-1:0]      table_fetch_addr
);

  // All state of the block.
  typedef struct packed {
    logic                         pready;
    logic                         pslverr;
    logic [31:0]                  prdata;
    logic [7:0]                   mem;
    logic [7:0]                   work;
    logic                         carry;
    logic                         tout;
    logic                         pdown;
    logic [mitf_pkg::PC_W-1:0]    pc;
    logic [mitf_pkg::PC_W-1:0]    stack_top;
    logic [mitf_pkg::PW_W-1:0]    prog_word;
    logic [mitf_pkg::PW_W-9:0]    tbl_high;
    logic [mitf_pkg::PC_W-1:0]    tbl_addr;
    logic                         busy;
    logic                         halted;
    logic [1:0]                   cycles;
    logic                         dest_mem;
    logic                         skip;
    logic                         push;
    logic [mitf_pkg::PC_W-1:0]    stack_data;
    logic                         wdt_clear;
    mitf_pkg::mitf_pre_t          pre_last;
    logic [31:0]                  instr;
  } mitf_state_t;

  mitf_state_t s_ff;
  mitf_state_t nxt_s;

  logic        apb_fire;
  logic        exec_go;
  logic        rd_err;
  logic [31:0] rd_data;
  logic [7:0]  addr8;

  // Tells whether an instruction code belongs to the conditional skips.
  function automatic logic mitf_is_skip(input mitf_pkg::mitf_op_t op);
    case (op)
      mitf_pkg::skip_when_zero, mitf_pkg::skip_when_zero_load_work,
      mitf_pkg::skip_when_bit_zero, mitf_pkg::skip_when_bit_one,
      mitf_pkg::skip_after_increment, mitf_pkg::skip_after_decrement,
      mitf_pkg::skip_after_increment_to_work, mitf_pkg::skip_after_decrement_to_work:
        mitf_is_skip = 1'b1;
      default:
        mitf_is_skip = 1'b0;
    endcase
  endfunction : mitf_is_skip

  // Bus decode; a transfer completes on the edge where the registered ready is high.
  assign addr8    = paddr[7:0];
  assign apb_fire = psel && penable && s_ff.pready;
  assign exec_go  = apb_fire && pwrite && (addr8 == mitf_pkg::OFS_INSTR) && !s_ff.pslverr;

  // Read data and error answer, captured on the same edge that raises ready.
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_err  = 1'b0;
    case (addr8)
      mitf_pkg::OFS_INSTR:      rd_data = s_ff.instr;
      mitf_pkg::OFS_MEM:        rd_data = {24'h00_0000, s_ff.mem};
      mitf_pkg::OFS_WORK:       rd_data = {24'h00_0000, s_ff.work};
      mitf_pkg::OFS_FLAGS:      rd_data = {29'h0000_0000, s_ff.pdown, s_ff.tout, s_ff.carry};
      mitf_pkg::OFS_PC:         rd_data = {20'h0_0000, s_ff.pc};
      mitf_pkg::OFS_STACK_TOP:  rd_data = {20'h0_0000, s_ff.stack_top};
      mitf_pkg::OFS_PROG_WORD:  rd_data = {17'h0_0000, s_ff.prog_word};
      mitf_pkg::OFS_STATUS:     rd_data = {9'h000, s_ff.tbl_high, 9'h000, s_ff.push, s_ff.skip,
                                           s_ff.dest_mem, s_ff.cycles, s_ff.halted, s_ff.busy};
      mitf_pkg::OFS_TABLE_ADDR: rd_data = {20'h0_0000, s_ff.tbl_addr};
      mitf_pkg::OFS_WAKE:       rd_err  = !pwrite;
      default:                  rd_err  = 1'b1;
    endcase
    // Status and table address are read only; instruction writes during the dummy slot or while halted are refused with an error.
    if (pwrite && (addr8 == mitf_pkg::OFS_STATUS || addr8 == mitf_pkg::OFS_TABLE_ADDR)) begin
      rd_err = 1'b1;
    end
    if (pwrite && addr8 == mitf_pkg::OFS_INSTR && (s_ff.busy || s_ff.halted)) begin
      rd_err = 1'b1;
    end
  end

  // Next state: bus answer, register writes and instruction execution.
  always_comb begin
    mitf_pkg::mitf_op_t        op;
    logic [2:0]                bidx;
    logic [7:0]                res;
    logic                      to_mem;
    logic                      to_work;
    logic                      skp;
    logic                      two;
    logic                      pc_set;
    logic [mitf_pkg::PC_W-1:0] new_pc;
    op      = mitf_pkg::idle_op;
    bidx    = 3'h0;
    res     = s_ff.mem;
    to_mem  = 1'b0;
    to_work = 1'b0;
    skp     = 1'b0;
    two     = 1'b0;
    pc_set  = 1'b0;
    new_pc  = s_ff.pc;
    nxt_s   = s_ff;
    nxt_s.push      = 1'b0;
    nxt_s.wdt_clear = 1'b0;
    nxt_s.busy      = 1'b0;
    if (psel && penable && !s_ff.pready) begin
      nxt_s.pready  = 1'b1;
      nxt_s.pslverr = rd_err;
      nxt_s.prdata  = rd_data;
    end else begin
      nxt_s.pready  = 1'b0;
      nxt_s.pslverr = 1'b0;
    end
    if (apb_fire && pwrite && !s_ff.pslverr) begin
      case (addr8)
        mitf_pkg::OFS_MEM:       nxt_s.mem = pwdata[7:0];
        mitf_pkg::OFS_WORK:      nxt_s.work = pwdata[7:0];
        mitf_pkg::OFS_FLAGS: begin
          nxt_s.carry = pwdata[mitf_pkg::FLG_CARRY];
          nxt_s.tout  = pwdata[mitf_pkg::FLG_TOUT];
          nxt_s.pdown = pwdata[mitf_pkg::FLG_PDOWN];
        end
        mitf_pkg::OFS_PC:        nxt_s.pc = pwdata[mitf_pkg::PC_W-1:0];
        mitf_pkg::OFS_STACK_TOP: nxt_s.stack_top = pwdata[mitf_pkg::PC_W-1:0];
        mitf_pkg::OFS_PROG_WORD: nxt_s.prog_word = pwdata[mitf_pkg::PW_W-1:0];
        mitf_pkg::OFS_WAKE:      nxt_s.halted = s_ff.halted && !pwdata[0];
        default: ;
      endcase
    end
    if (exec_go) begin
      op   = mitf_pkg::mitf_op_t'(pwdata[mitf_pkg::OP_LSB +: 6]);
      bidx = pwdata[mitf_pkg::BIT_LSB +: 3];
      nxt_s.instr    = pwdata;
      nxt_s.pre_last = mitf_pkg::mitf_pre_none;
      case (op)
        mitf_pkg::rotate_right_to_work:        begin res = {s_ff.mem[0], s_ff.mem[7:1]}; to_work = 1'b1; end
        mitf_pkg::rotate_right_in_place:       begin res = {s_ff.mem[0], s_ff.mem[7:1]}; to_mem = 1'b1; end
        mitf_pkg::rotate_left_to_work:         begin res = {s_ff.mem[6:0], s_ff.mem[7]}; to_work = 1'b1; end
        mitf_pkg::rotate_left_in_place:        begin res = {s_ff.mem[6:0], s_ff.mem[7]}; to_mem = 1'b1; end
        mitf_pkg::rotate_right_carry_to_work, mitf_pkg::rotate_right_carry_in_place: begin
          res = {s_ff.carry, s_ff.mem[7:1]};
          nxt_s.carry = s_ff.mem[0];
          to_work = (op == mitf_pkg::rotate_right_carry_to_work);
          to_mem  = !to_work;
        end
        mitf_pkg::rotate_left_carry_to_work, mitf_pkg::rotate_left_carry_in_place: begin
          res = {s_ff.mem[6:0], s_ff.carry};
          nxt_s.carry = s_ff.mem[7];
          to_work = (op == mitf_pkg::rotate_left_carry_to_work);
          to_mem  = !to_work;
        end
        mitf_pkg::copy_mem_to_work:  begin res = s_ff.mem; to_work = 1'b1; end
        mitf_pkg::copy_work_to_mem:  begin res = s_ff.work; to_mem = 1'b1; end
        mitf_pkg::copy_imm_to_work:  begin res = pwdata[mitf_pkg::IMM_LSB +: 8]; to_work = 1'b1; end
        mitf_pkg::bit_clear_op:      begin res = s_ff.mem & ~(8'h01 << bidx); to_mem = 1'b1; end
        mitf_pkg::bit_set_op:        begin res = s_ff.mem | (8'h01 << bidx); to_mem = 1'b1; end
        mitf_pkg::jump_op: begin
          two = 1'b1;
          pc_set = 1'b1;
          new_pc = pwdata[mitf_pkg::ADDR_LSB +: mitf_pkg::PC_W];
        end
        mitf_pkg::call_op: begin
          two = 1'b1;
          pc_set = 1'b1;
          new_pc = pwdata[mitf_pkg::ADDR_LSB +: mitf_pkg::PC_W];
          nxt_s.push       = 1'b1;
          nxt_s.stack_data = s_ff.pc + 12'h001;
        end
        mitf_pkg::subroutine_exit, mitf_pkg::interrupt_exit: begin
          two = 1'b1;
          pc_set = 1'b1;
          new_pc = s_ff.stack_top;
        end
        mitf_pkg::subroutine_exit_load_work: begin
          two = 1'b1;
          pc_set = 1'b1;
          new_pc = s_ff.stack_top;
          res = pwdata[mitf_pkg::IMM_LSB +: 8];
          to_work = 1'b1;
        end
        mitf_pkg::skip_when_zero:           skp = (s_ff.mem == 8'h00);
        mitf_pkg::skip_when_zero_load_work: begin res = s_ff.mem; to_work = 1'b1; skp = (s_ff.mem == 8'h00); end
        mitf_pkg::skip_when_bit_zero:       skp = !s_ff.mem[bidx];
        mitf_pkg::skip_when_bit_one:        skp = s_ff.mem[bidx];
        mitf_pkg::skip_after_increment, mitf_pkg::skip_after_increment_to_work: begin
          res = s_ff.mem + 8'h01;
          skp = (res == 8'h00);
          to_work = (op == mitf_pkg::skip_after_increment_to_work);
          to_mem  = !to_work;
        end
        mitf_pkg::skip_after_decrement, mitf_pkg::skip_after_decrement_to_work: begin
          res = s_ff.mem - 8'h01;
          skp = (res == 8'h00);
          to_work = (op == mitf_pkg::skip_after_decrement_to_work);
          to_mem  = !to_work;
        end
        mitf_pkg::table_read_current_page, mitf_pkg::table_read_last_page: begin
          two = 1'b1;
          nxt_s.tbl_addr = (op == mitf_pkg::table_read_last_page) ? {mitf_pkg::LAST_PAGE, s_ff.work}
                                                                  : {s_ff.pc[11:8], s_ff.work};
          nxt_s.tbl_high = s_ff.prog_word[mitf_pkg::PW_W-1:8];
          res = s_ff.prog_word[7:0];
          to_mem = 1'b1;
        end
        mitf_pkg::clear_op:    begin res = 8'h00; to_mem = 1'b1; end
        mitf_pkg::set_byte_op: begin res = 8'hff; to_mem = 1'b1; end
        mitf_pkg::watchdog_clear: begin
          nxt_s.tout  = 1'b0;
          nxt_s.pdown = 1'b0;
          nxt_s.wdt_clear = 1'b1;
        end
        mitf_pkg::watchdog_preclear_first, mitf_pkg::watchdog_preclear_second: begin
          // Only the alternate of the previous instruction completes the pair.
          if ((op == mitf_pkg::watchdog_preclear_first && s_ff.pre_last == mitf_pkg::mitf_pre_second) ||
              (op == mitf_pkg::watchdog_preclear_second && s_ff.pre_last == mitf_pkg::mitf_pre_first)) begin
            nxt_s.tout  = 1'b0;
            nxt_s.pdown = 1'b0;
            nxt_s.wdt_clear = 1'b1;
          end else begin
            nxt_s.pre_last = (op == mitf_pkg::watchdog_preclear_first) ? mitf_pkg::mitf_pre_first
                                                                       : mitf_pkg::mitf_pre_second;
          end
        end
        mitf_pkg::nibble_exchange_in_place: begin res = {s_ff.mem[3:0], s_ff.mem[7:4]}; to_mem = 1'b1; end
        mitf_pkg::nibble_exchange_to_work:  begin res = {s_ff.mem[3:0], s_ff.mem[7:4]}; to_work = 1'b1; end
        mitf_pkg::power_down_op: begin
          nxt_s.tout   = 1'b0;
          nxt_s.pdown  = 1'b1;
          nxt_s.halted = 1'b1;
          nxt_s.wdt_clear = 1'b1;
        end
        default: ; // Idle consumes one cycle and leaves memory, work and flags unchanged.
      endcase
      // A memory result aimed at the program counter low byte redirects flow.
      if (to_mem && pwdata[mitf_pkg::PC_LOW_POS]) begin
        to_mem = 1'b0;
        two    = 1'b1;
        pc_set = 1'b1;
        new_pc = {s_ff.pc[11:8], res};
      end
      if (skp) begin
        two = 1'b1;
      end
      if (to_mem) begin
        nxt_s.mem = res;
      end
      if (to_work) begin
        nxt_s.work = res;
      end
      nxt_s.pc       = pc_set ? new_pc : (s_ff.pc + (skp ? 12'h002 : 12'h001));
      nxt_s.busy     = two;
      nxt_s.cycles   = two ? mitf_pkg::CYC_TWO : mitf_pkg::CYC_ONE;
      nxt_s.dest_mem = to_mem;
      nxt_s.skip     = skp;
    end
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Outputs come straight from the state register.
  assign pready               = s_ff.pready;
  assign pslverr              = s_ff.pslverr;
  assign prdata               = s_ff.prdata;
  assign clock_stop           = s_ff.halted;
  assign watchdog_clear_pulse = s_ff.wdt_clear;
  assign stack_push           = s_ff.push;
  assign stack_push_data      = s_ff.stack_data;
  assign table_fetch_addr     = s_ff.tbl_addr;

  // Checks on the execution results.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [5:0] go_op;
  assign go_op = pwdata[5:0];

  rot_plain_a: assert property (exec_go && go_op == 6'(mitf_pkg::rotate_left_in_place) && !pwdata[9]
    |=> s_ff.mem == {$past(s_ff.mem[6:0]), $past(s_ff.mem[7])} && s_ff.carry == $past(s_ff.carry) && !s_ff.busy)
    else $error("plain rotate wrong");
  rot_carry_a: assert property (exec_go && go_op == 6'(mitf_pkg::rotate_right_carry_to_work)
    |=> s_ff.carry == $past(s_ff.mem[0]) && s_ff.work[7] == $past(s_ff.carry))
    else $error("carry rotate wrong");
  copy_work_a: assert property (exec_go && go_op == 6'(mitf_pkg::copy_mem_to_work)
    |=> s_ff.work == $past(s_ff.mem) && s_ff.cycles == 2'h1 && !s_ff.busy)
    else $error("copy wrong");
  bit_set_a: assert property (exec_go && go_op == 6'(mitf_pkg::bit_set_op) && !pwdata[9]
    |=> s_ff.mem == ($past(s_ff.mem) | (8'h01 << $past(pwdata[8:6]))))
    else $error("bit set wrong");
  branch_two_a: assert property (exec_go && go_op == 6'(mitf_pkg::jump_op)
    |=> s_ff.busy ##1 !s_ff.busy && s_ff.cycles == 2'h2)
    else $error("jump not two cycles");
  skip_time_a: assert property (exec_go && mitf_is_skip(mitf_pkg::mitf_op_t'(go_op)) && !pwdata[9]
    |=> s_ff.busy == s_ff.skip)
    else $error("skip timing wrong");
  pc_low_dest_a: assert property (exec_go && go_op == 6'(mitf_pkg::clear_op) && pwdata[9]
    |=> s_ff.busy && s_ff.pc[7:0] == 8'h00 && s_ff.mem == $past(s_ff.mem))
    else $error("pc low write not two cycles");
  preclear_lone_a: assert property (exec_go && go_op == 6'(mitf_pkg::watchdog_preclear_first)
    && s_ff.pre_last != mitf_pkg::mitf_pre_second |=> s_ff.tout == $past(s_ff.tout)
    && s_ff.pdown == $past(s_ff.pdown) && !watchdog_clear_pulse)
    else $error("lone pre-clear changed flags");
  halt_flags_a: assert property (exec_go && go_op == 6'(mitf_pkg::power_down_op)
    |=> s_ff.pdown && !s_ff.tout && s_ff.halted && !s_ff.busy && watchdog_clear_pulse)
    else $error("power-down flags wrong");
  wdt_clear_a: assert property (exec_go && go_op == 6'(mitf_pkg::watchdog_clear)
    |=> watchdog_clear_pulse && !s_ff.tout && !s_ff.pdown && !s_ff.busy)
    else $error("watchdog clear wrong");
  call_push_a: assert property (exec_go && go_op == 6'(mitf_pkg::call_op)
    |=> stack_push && stack_push_data == $past(s_ff.pc) + 12'h001 && s_ff.pc == $past(pwdata[27:16]))
    else $error("call push wrong");

endmodule : mitf_core

// ### verilog/mitf_pkg.sv
package mitf_pkg;

  // Register byte offsets on the APB slave.
  localparam logic [7:0] OFS_INSTR      = 8'h00;
  localparam logic [7:0] OFS_MEM        = 8'h04;
  localparam logic [7:0] OFS_WORK       = 8'h08;
  localparam logic [7:0] OFS_FLAGS      = 8'h0c;
  localparam logic [7:0] OFS_PC         = 8'h10;
  localparam logic [7:0] OFS_STACK_TOP  = 8'h14;
  localparam logic [7:0] OFS_PROG_WORD  = 8'h18;
  localparam logic [7:0] OFS_STATUS     = 8'h1c;
  localparam logic [7:0] OFS_TABLE_ADDR = 8'h20;
  localparam logic [7:0] OFS_WAKE       = 8'h24;

  // Widths of the program counter and the program word.
  localparam int unsigned PC_W = 12;
  localparam int unsigned PW_W = 15;

  // Field positions inside the instruction register.
  localparam int unsigned OP_LSB     = 0;
  localparam int unsigned BIT_LSB    = 6;
  localparam int unsigned PC_LOW_POS = 9;
  localparam int unsigned IMM_LSB    = 16;
  localparam int unsigned ADDR_LSB   = 16;

  // Flag register bit positions.
  localparam int unsigned FLG_CARRY = 0;
  localparam int unsigned FLG_TOUT  = 1;
  localparam int unsigned FLG_PDOWN = 2;

  // Values after reset and the last program page.
  localparam logic [7:0]      RST_BYTE = 8'h00;
  localparam logic [PC_W-1:0] RST_PC   = 12'h000;
  localparam logic [3:0]      LAST_PAGE = 4'hf;

  // Cycle counts of one and two machine cycles.
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;

  // Last pre-clear watchdog instruction seen.
  typedef enum logic [1:0] {mitf_pre_none, mitf_pre_first, mitf_pre_second} mitf_pre_t;

  // Instruction codes accepted by the instruction register.
  typedef enum logic [5:0] {
    idle_op, rotate_right_to_work, rotate_right_in_place, rotate_right_carry_to_work,
    rotate_right_carry_in_place, rotate_left_to_work, rotate_left_in_place,
    rotate_left_carry_to_work, rotate_left_carry_in_place, copy_mem_to_work,
    copy_work_to_mem, copy_imm_to_work, bit_clear_op, bit_set_op, jump_op, call_op,
    subroutine_exit, subroutine_exit_load_work, interrupt_exit, skip_when_zero,
    skip_when_zero_load_work, skip_when_bit_zero, skip_when_bit_one, skip_after_increment,
    skip_after_decrement, skip_after_increment_to_work, skip_after_decrement_to_work,
    table_read_current_page, table_read_last_page, clear_op, set_byte_op, watchdog_clear,
    watchdog_preclear_first, watchdog_preclear_second, nibble_exchange_in_place,
    nibble_exchange_to_work, power_down_op
  } mitf_op_t;

endpackage : mitf_pkg
